/* lgt_pkg.sv */
// lockup guard timer package: register map, field layout, reset values
// assumes a 32-bit classic wishbone slave port with word-aligned registers
package lgt_pkg;

  // register byte offsets
  localparam logic [3:0] LGT_CTRL_OFS = 4'h0;
  localparam logic [3:0] LGT_MODE_OFS = 4'h4;
  localparam logic [3:0] LGT_STAT_OFS = 4'h8;
  localparam logic [3:0] LGT_PROT_OFS = 4'hc;

  // ctrl register: reload command with key
  localparam logic [15:0] LGT_RELOAD_KEY = 16'h5fa0;
  localparam int LGT_KEY_LSB = 16;

  // mode register field positions
  localparam int LGT_RLD_LSB = 0;
  localparam int LGT_DLT_LSB = 12;
  localparam int LGT_PRE_LSB = 24;
  localparam int LGT_EN_BIT = 27;
  localparam int LGT_DBG_BIT = 28;
  localparam int LGT_SRC_BIT = 29;

  // protection unlock key, low half of the protect register
  localparam logic [15:0] LGT_UNLOCK_KEY = 16'h35ca;

  // reset values
  localparam logic [11:0] LGT_RLD_RST = 12'hfff;
  localparam logic [11:0] LGT_DLT_RST = 12'hfff;
  localparam logic [2:0] LGT_PRE_RST = 3'h0;

  // hold time of the system reset pulse, in fast clock cycles
  localparam logic [3:0] LGT_RST_HOLD = 4'h8;

  // cause of the last watchdog reset
  typedef enum logic [1:0] {
    LGT_CAUSE_NONE  = 2'b00,
    LGT_CAUSE_UFLOW = 2'b01,
    LGT_CAUSE_EARLY = 2'b10
  } lgt_cause_t;

  // wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } lgt_wb_req_t;

  // configuration handed to the counter core
  typedef struct packed {
    logic enable;
    logic dbg_freeze;
    logic src_ext;
    logic [2:0] prescale;
    logic [11:0] reload;
    logic [11:0] delta;
  } lgt_cfg_t;

endpackage

/* lgt_tick.sv */
// lockup guard timer slow-clock tick: turns a slow oscillator level into an enable
// assumes both oscillator levels are already synchronous to clk_i
`timescale 1ns/10ps
module lgt_tick (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // oscillator levels
  input wire logic slow_internal_oscillator_i,
  input wire logic slow_external_crystal_i,
  input wire logic src_ext_i,
  // one-cycle enable per rising slow edge
  output logic tick_o
);
  logic sel_lvl;
  logic prev_reg;

  // source mux
  assign sel_lvl = src_ext_i ? slow_external_crystal_i : slow_internal_oscillator_i;

  // remember last level for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sel_lvl;
    end
  end

  // a source switch may cause one extra tick, harmless for a timeout
  assign tick_o = sel_lvl & ~prev_reg;
endmodule // lgt_tick

/* lgt_timer.sv */
// lockup guard timer: windowed 12-bit down counter with wishbone registers
// assumes a 20 MHz clk_i, slow oscillators sampled synchronously, classic wishbone
// Operation
// - 12-bit down counter behind 3-bit prescaler
// - underflow without reload resets the system
// - reload outside delta window resets system
// - optional freeze while processor is debug-halted
// - write protection locks configuration registers
// - clock from slow internal or external oscillator
`timescale 1ns/10ps
module lgt_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire lgt_pkg::lgt_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // oscillators and debug
  input wire logic slow_internal_oscillator_i,
  input wire logic slow_external_crystal_i,
  input wire logic dbg_halt_i,
  // system reset request
  output logic sys_rst_o
);
  import lgt_pkg::*;

  lgt_cfg_t cfg_reg;
  logic locked_reg;
  logic [11:0] cnt_reg;
  logic [7:0] pre_reg;
  logic [3:0] hold_reg;
  lgt_cause_t cause_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic tick;
  logic run;
  logic pre_done;
  logic wr_hit;
  logic mode_wr;
  logic reload_req;
  logic in_window;
  logic uflow;
  logic early;
  logic fire;

  // prescaler divide: 2^setting slow ticks per count
  function automatic logic [7:0] pre_mask(input logic [2:0] p);
    pre_mask = 8'(({7'h0, 1'b1} << p) - 8'h1);
  endfunction

  lgt_tick u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .slow_internal_oscillator_i(slow_internal_oscillator_i),
    .slow_external_crystal_i(slow_external_crystal_i),
    .src_ext_i(cfg_reg.src_ext),
    .tick_o(tick)
  );

  // bus strobes; ack is a single cycle then drops
  assign wr_hit = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~ack_reg;
  assign reload_req = wr_hit && wb_req_i.adr == LGT_CTRL_OFS && (&wb_req_i.sel)
    && wb_req_i.dat[LGT_KEY_LSB +: 16] == LGT_RELOAD_KEY;
  // mode write that lands; the lock refuses it but the bus still acks
  assign mode_wr = wr_hit && wb_req_i.adr == LGT_MODE_OFS && !locked_reg;
  // window: reload allowed only while count is at or below delta
  assign in_window = cnt_reg <= cfg_reg.delta;
  assign run = cfg_reg.enable & ~(cfg_reg.dbg_freeze & dbg_halt_i);
  assign pre_done = (pre_reg & pre_mask(cfg_reg.prescale)) == pre_mask(cfg_reg.prescale);
  assign uflow = run & tick & pre_done & (cnt_reg == 12'h000);
  assign early = cfg_reg.enable & reload_req & ~in_window;
  assign fire = (uflow | early) & (hold_reg == 4'h0);

  // bus acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
    end
  end
  assign wb_ack_o = ack_reg;

  // configuration writes, blocked while locked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= '{enable: 1'b0, dbg_freeze: 1'b0, src_ext: 1'b0, prescale: LGT_PRE_RST,
                   reload: LGT_RLD_RST, delta: LGT_DLT_RST};
    end else if (mode_wr) begin
      cfg_reg.reload <= wb_req_i.dat[LGT_RLD_LSB +: 12];
      cfg_reg.delta <= wb_req_i.dat[LGT_DLT_LSB +: 12];
      cfg_reg.prescale <= wb_req_i.dat[LGT_PRE_LSB +: 3];
      cfg_reg.enable <= wb_req_i.dat[LGT_EN_BIT];
      cfg_reg.dbg_freeze <= wb_req_i.dat[LGT_DBG_BIT];
      cfg_reg.src_ext <= wb_req_i.dat[LGT_SRC_BIT];
    end
  end

  // protection: key unlocks, any other value locks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locked_reg <= 1'b0;
    end else if (wr_hit && wb_req_i.adr == LGT_PROT_OFS) begin
      locked_reg <= wb_req_i.dat[15:0] != LGT_UNLOCK_KEY;
    end
  end

  // prescaler, restarted on reload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_reg <= 8'h00;
    end else if (reload_req || !cfg_reg.enable) begin
      pre_reg <= 8'h00;
    end else if (run && tick) begin
      pre_reg <= pre_done ? 8'h00 : 8'(pre_reg + 8'h01);
    end
  end

  // down counter; a mode write while idle loads the new reload value at once,
  // otherwise enabling in that write would start from the stale one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= LGT_RLD_RST;
    end else if (mode_wr && !cfg_reg.enable) begin
      cnt_reg <= wb_req_i.dat[LGT_RLD_LSB +: 12];
    end else if (!cfg_reg.enable || (reload_req && in_window) || fire) begin
      cnt_reg <= cfg_reg.reload;
    end else if (run && tick && pre_done && cnt_reg != 12'h000) begin
      // zero holds while a pulse is still out, so the count never wraps
      cnt_reg <= 12'(cnt_reg - 12'h001);
    end
  end

  // reset pulse stretcher and cause record
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_reg <= 4'h0;
      cause_reg <= LGT_CAUSE_NONE;
    end else if (fire) begin
      hold_reg <= LGT_RST_HOLD;
      cause_reg <= uflow ? LGT_CAUSE_UFLOW : LGT_CAUSE_EARLY;
    end else if (hold_reg != 4'h0) begin
      hold_reg <= 4'(hold_reg - 4'h1);
    end
  end
  assign sys_rst_o = hold_reg != 4'h0;

  // read data, registered; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_reg <= 32'h0;
    end else begin
      case (wb_req_i.adr)
        LGT_MODE_OFS: rdat_reg <= {2'h0, cfg_reg.src_ext, cfg_reg.dbg_freeze, cfg_reg.enable,
                                   cfg_reg.prescale, cfg_reg.delta, cfg_reg.reload};
        LGT_STAT_OFS: rdat_reg <= {16'h0, 1'b0, locked_reg, cause_reg, cnt_reg};
        LGT_PROT_OFS: rdat_reg <= {31'h0, locked_reg};
        default: rdat_reg <= 32'h0;
      endcase
    end
  end
  assign wb_dat_o = rdat_reg;

  // checks
  sequence s_early;
    cfg_reg.enable && reload_req && !in_window && hold_reg == 4'h0;
  endsequence
  AST_UFLOW_RST: assert property (@(posedge clk_i) disable iff (rst_i)
    uflow && hold_reg == 4'h0 |=> sys_rst_o && cause_reg == LGT_CAUSE_UFLOW)
    else $error("underflow did not reset");
  AST_EARLY_RST: assert property (@(posedge clk_i) disable iff (rst_i)
    s_early |=> sys_rst_o)
    else $error("early reload did not reset");
  AST_RLD_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    reload_req && in_window && hold_reg == 4'h0 |=> cnt_reg == $past(cfg_reg.reload)
    && pre_reg == 8'h00)
    else $error("reload not applied");
  AST_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_reg.dbg_freeze && dbg_halt_i && !reload_req && cfg_reg.enable
    && !$past(rst_i) |=> $stable(cnt_reg) || sys_rst_o)
    else $error("counter moved while frozen");
  AST_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    locked_reg |=> $stable(cfg_reg))
    else $error("locked config changed");
  AST_DEC: assert property (@(posedge clk_i) disable iff (rst_i)
    run && tick && pre_done && !reload_req && cnt_reg != 12'h000
    |=> cnt_reg == 12'($past(cnt_reg) - 12'h001))
    else $error("count step wrong");
  AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(sys_rst_o) |-> sys_rst_o [*8] ##1 !sys_rst_o)
    else $error("reset pulse length wrong");
  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  // reset pulse only follows an underflow or an early reload
  AST_RST_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(sys_rst_o) |-> $past(uflow || early))
    else $error("reset pulse without cause");
  // a reload inside the window must not reset
  sequence s_in_window;
    cfg_reg.enable && reload_req && in_window && hold_reg == 4'h0 && !uflow;
  endsequence
  AST_WIN_OK: assert property (@(posedge clk_i) disable iff (rst_i)
    s_in_window |=> !sys_rst_o)
    else $error("reload in window reset the system");
  // zero holds or reloads, never wraps to the top
  AST_NO_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_reg.enable && cnt_reg == 12'h000 && !reload_req
    |=> cnt_reg == 12'h000 || cnt_reg == $past(cfg_reg.reload))
    else $error("count wrapped");
  // idle timer sits at the reload value with the prescaler cleared
  AST_IDLE_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_reg.enable |=> cnt_reg == cfg_reg.reload)
    else $error("idle count not at reload value");
  AST_PRE_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_reg.enable |=> pre_reg == 8'h00)
    else $error("prescaler not cleared while idle");
  // ack only answers a request that stood at the previous edge
  AST_ACK_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(wb_req_i.cyc && wb_req_i.stb))
    else $error("ack without request");
endmodule // lgt_timer

/* lgt_timer_tb.sv */
// lockup guard timer bench: reset values, window, underflow, freeze, source, lock
// assumes every wishbone request is answered by a one-cycle ack
`timescale 1ns/10ps
module lgt_timer_tb;
  import lgt_pkg::*;
  logic clk_i, rst_i, dbg_halt_i, osc_int, osc_ext, run_int, run_ext;
  logic [2:0] div_reg;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, sys_rst_o;
  lgt_wb_req_t req;
  int err_total, comparisons;
  lgt_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .slow_internal_oscillator_i(osc_int),
    .slow_external_crystal_i(osc_ext), .dbg_halt_i(dbg_halt_i), .sys_rst_o(sys_rst_o));
  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // slow oscillators: one rising edge every 8 cycles, each gated on its own
  always @(posedge clk_i) begin
    div_reg <= div_reg + 3'h1;
    osc_int <= run_int & div_reg[2];
    osc_ext <= run_ext & div_reg[2];
  end
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic hang();
    err_total++;
    $display("MISMATCH wait expected done seen timeout");
    give_verdict();
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // classic single cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int n = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) hang();
    rd = wb_dat_o;
    req <= '0;
  endtask
  // mode word: flg is {src, freeze, enable}
  function automatic logic [31:0] mode(input logic [11:0] rld, input logic [11:0] dlt,
    input logic [2:0] pre, input logic [2:0] flg);
    return {2'h0, flg, pre, dlt, rld};
  endfunction
  task automatic expect_reset(input logic [1:0] cause);
    int n = 0;
    while (sys_rst_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (sys_rst_o !== 1'b1) hang();
    n = 0;
    while (sys_rst_o === 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk("reset pulse", 32'd8, n);
    wb(1'b0, LGT_STAT_OFS, 32'h0);
    chk("cause", cause, rd[13:12]);
  endtask
  // let the counter run a while, then read the count
  task automatic run_cnt();
    repeat (100) @(posedge clk_i);
    wb(1'b0, LGT_STAT_OFS, 32'h0);
  endtask
  task automatic t_reset();
    wb(1'b0, LGT_MODE_OFS, 32'h0);
    chk("mode reset", 32'h00ffffff, rd);
    wb(1'b0, LGT_STAT_OFS, 32'h0);
    chk("stat reset", 32'h0fff, rd[14:0]);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_window();
    wb(1'b1, LGT_MODE_OFS, mode(12'h004, 12'hfff, 3'h0, 3'h1));
    expect_reset(2'h1);
    // disable first: an enabled timer keeps its count across a mode write
    wb(1'b1, LGT_MODE_OFS, mode(12'h100, 12'h010, 3'h0, 3'h0));
    wb(1'b1, LGT_MODE_OFS, mode(12'h100, 12'h010, 3'h0, 3'h1));
    wb(1'b1, LGT_CTRL_OFS, {LGT_RELOAD_KEY, 16'h0});
    expect_reset(2'h2);
    // long prescale so no step lands between reload and read
    wb(1'b1, LGT_MODE_OFS, mode(12'h100, 12'hfff, 3'h3, 3'h0));
    wb(1'b1, LGT_MODE_OFS, mode(12'h100, 12'hfff, 3'h3, 3'h1));
    run_cnt();
    run_cnt();
    chk("counting", 1'b1, rd[11:0] < 12'h100);
    wb(1'b1, LGT_CTRL_OFS, {LGT_RELOAD_KEY, 16'h0});
    wb(1'b0, LGT_STAT_OFS, 32'h0);
    chk("reloaded", 32'h100, rd[11:0]);
    chk("no reset", 1'b0, sys_rst_o);
  endtask
  task automatic t_freeze_src();
    dbg_halt_i <= 1'b1;
    wb(1'b1, LGT_MODE_OFS, mode(12'h100, 12'hfff, 3'h0, 3'h2));
    wb(1'b1, LGT_MODE_OFS, mode(12'h100, 12'hfff, 3'h0, 3'h3));
    run_cnt();
    chk("frozen", 32'h100, rd[11:0]);
    dbg_halt_i <= 1'b0;
    run_cnt();
    chk("thawed", 1'b1, rd[11:0] < 12'h100);
    wb(1'b1, LGT_MODE_OFS, mode(12'h100, 12'hfff, 3'h0, 3'h4));
    wb(1'b1, LGT_MODE_OFS, mode(12'h100, 12'hfff, 3'h0, 3'h5));
    run_cnt();
    chk("crystal idle", 32'h100, rd[11:0]);
    run_ext <= 1'b1;
    run_cnt();
    chk("crystal runs", 1'b1, rd[11:0] < 12'h100);
  endtask
  task automatic t_lock();
    wb(1'b1, LGT_MODE_OFS, mode(12'h123, 12'h456, 3'h5, 3'h0));
    wb(1'b1, LGT_PROT_OFS, 32'h0);
    wb(1'b0, LGT_STAT_OFS, 32'h0);
    chk("locked", 1'b1, rd[14]);
    wb(1'b1, LGT_MODE_OFS, mode(12'hfff, 12'hfff, 3'h7, 3'h0));
    wb(1'b0, LGT_MODE_OFS, 32'h0);
    chk("mode kept", 32'h05456123, rd);
    wb(1'b1, LGT_PROT_OFS, {16'h0, LGT_UNLOCK_KEY});
    wb(1'b0, LGT_PROT_OFS, 32'h0);
    chk("unlocked", 1'b0, rd[0]);
    wb(1'b1, LGT_MODE_OFS, mode(12'hfff, 12'h0ab, 3'h7, 3'h0));
    wb(1'b0, LGT_MODE_OFS, 32'h0);
    chk("mode write", 32'h070abfff, rd);
  endtask
  // reset while locked clears the lock and the configuration
  task automatic t_rerst();
    wb(1'b1, LGT_PROT_OFS, 32'h0);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
  endtask
  // reset, then the scenarios in turn
  initial begin
    rst_i = 1'b1;
    req = '0;
    dbg_halt_i = 1'b0;
    run_int = 1'b1;
    run_ext = 1'b0;
    div_reg = 3'h0;
    osc_int = 1'b0;
    osc_ext = 1'b0;
    err_total = 0;
    comparisons = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_window();
    t_freeze_src();
    t_lock();
    t_rerst();
    give_verdict();
  end
endmodule // lgt_timer_tb
